// ===== adc_seq_pkg.sv
package adc_seq_pkg;

    // ------------------------------------------------------------
    // Field widths and codes
    // ------------------------------------------------------------
    localparam int          RES_W        = 8;
    localparam int          CH_W         = 4;
    localparam int          SLOTS        = 4;
    localparam int          PTR_W        = 2;
    localparam int          DIV_W        = 8;
    localparam int          DLY_W        = 8;
    localparam int          NUM_CH       = 12;
    localparam int          CONV_CYCLES  = 10;
    localparam logic [1:0]  SCAN_SINGLE  = 2'h0;
    localparam logic [1:0]  SCAN_FOUR    = 2'h1;
    localparam logic [PTR_W-1:0] PTR_RESET = 2'h3;
    localparam logic [RES_W-1:0] CODE_ZERO = 8'h00;
    localparam logic [RES_W-1:0] CODE_FULL = 8'hFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ      = 20;
    localparam int          CONV_MHZ_MAX = 2;
    localparam int          MIN_DIV      = (CLK_MHZ + CONV_MHZ_MAX - 1) / CONV_MHZ_MAX;
    localparam int          EN_SETTLE_US = 30;
    localparam int          EN_SETTLE_CYC = EN_SETTLE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic [1:0]      scan;
        logic            repeat_select;
        logic [CH_W-1:0] channel;
    } converter_mode_s;

    typedef struct packed {
        logic [PTR_W-1:0] last_slot_pointer;
        logic             overrun_flag;
        logic             busy;
        logic             done;
    } converter_status_s;

endpackage : adc_seq_pkg

// ===== adc_conversion_sequencer.sv
`timescale 1ns/1ps
module adc_conversion_sequencer #(
    parameter int DIV_DEFAULT = 10
) (
    // Clock and reset
    input  wire logic                               sys_clk_in,
    input  wire logic                               sys_rst_in,
    // Control
    input  wire logic                               converter_enable_bit_in,
    input  wire logic                               int_enable_in,
    input  wire adc_seq_pkg::converter_mode_s       converter_mode_reg_in,
    input  wire logic                               start_set_in,
    input  wire logic                               start_clear_in,
    input  wire logic [adc_seq_pkg::DIV_W-1:0]      clk_div_in,
    input  wire logic [adc_seq_pkg::DLY_W-1:0]      sample_delay_in,
    input  wire logic                               overrun_clear_in,
    input  wire logic                               result_read_in,
    input  wire logic [adc_seq_pkg::PTR_W-1:0]      result_read_slot_in,
    // Analog front end
    input  wire logic                               comparator_in,
    output logic [adc_seq_pkg::CH_W-1:0]            mux_select_out,
    output logic                                    hold_out,
    output logic [adc_seq_pkg::RES_W-1:0]           dac_code_out,
    // Status and results
    output logic                                    start_out,
    output adc_seq_pkg::converter_status_s          converter_status_reg_out,
    output logic [adc_seq_pkg::SLOTS*adc_seq_pkg::RES_W-1:0] result_slots_out,
    output logic                                    irq_out
);
    import adc_seq_pkg::*;

    initial begin
        if (DIV_DEFAULT < 1 || DIV_DEFAULT > 255) begin
            $error("DIV_DEFAULT out of range");
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    seq_state_e        state_reg;
    logic [DIV_W-1:0]  div_cnt_reg;
    logic              tick;
    logic [DLY_W-1:0]  dly_cnt_reg;
    logic [3:0]        bit_cnt_reg;
    logic [RES_W-1:0]  sar_reg;
    logic [1:0]        scan_idx_reg;
    logic [CH_W-1:0]   chan_reg;
    converter_mode_s   mode_reg;
    logic [RES_W-1:0]  slot_reg [SLOTS];
    logic [SLOTS-1:0]  full_reg;
    logic              store;
    logic [PTR_W-1:0]  wr_slot;
    logic [DIV_W-1:0]  div_eff;
    logic              busy_reg;
    logic [PTR_W-1:0]  ptr_reg;
    logic              ovr_reg;
    logic              done_reg;

    // One writer per flag; the status word is only their concatenation
    assign converter_status_reg_out = '{ptr_reg, ovr_reg, busy_reg, done_reg};

    function automatic logic [CH_W-1:0] chan_add(input logic [CH_W-1:0] base,
                                                  input logic [1:0] off);
        logic [CH_W:0] s;
        s = {1'b0, base} + {3'b000, off};
        if (s >= (CH_W+1)'(NUM_CH)) begin
            s = s - (CH_W+1)'(NUM_CH);
        end
        chan_add = s[CH_W-1:0];
    endfunction : chan_add

    // Zero divider falls back to the default
    assign div_eff = (clk_div_in == '0) ? DIV_W'(DIV_DEFAULT) : clk_div_in;

    // ------------------------------------------------------------
    // Converter clock divider
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || state_reg == ST_IDLE) begin
            div_cnt_reg <= '0;
            tick        <= 1'b0;
        end else if (div_cnt_reg >= div_eff - DIV_W'(1)) begin
            div_cnt_reg <= '0;
            tick        <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + DIV_W'(1);
            tick        <= 1'b0;
        end
    end

    // Tenth converter tick (count 9) is the store cycle, two ticks after the last bit decision
    assign store   = (state_reg == ST_CONV) && tick && (bit_cnt_reg == 4'(CONV_CYCLES - 1));
    assign wr_slot = ptr_reg + PTR_W'(1);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !converter_enable_bit_in) begin
            state_reg    <= ST_IDLE;
            start_out    <= 1'b0;
            hold_out     <= 1'b0;
            dly_cnt_reg  <= '0;
            bit_cnt_reg  <= '0;
            sar_reg      <= CODE_ZERO;
            scan_idx_reg <= '0;
            chan_reg     <= '0;
            mode_reg     <= '0;
            dac_code_out <= CODE_ZERO;
            busy_reg     <= 1'b0;
        end else begin
            if (start_clear_in) begin
                start_out <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    // Reserved channel codes are not started
                    if (start_set_in && converter_mode_reg_in.channel < CH_W'(NUM_CH)
                        && !converter_mode_reg_in.scan[1]) begin
                        start_out    <= 1'b1;
                        mode_reg     <= converter_mode_reg_in;
                        chan_reg     <= converter_mode_reg_in.channel;
                        scan_idx_reg <= '0;
                        dly_cnt_reg  <= sample_delay_in;
                        hold_out     <= 1'b1;
                        state_reg    <= ST_SAMPLE;
                        busy_reg     <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (dly_cnt_reg == '0) begin
                            state_reg    <= ST_CONV;
                            bit_cnt_reg  <= '0;
                            sar_reg      <= CODE_ZERO;
                            dac_code_out <= 8'h80;
                        end else begin
                            dly_cnt_reg <= dly_cnt_reg - DLY_W'(1);
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg < 4'(RES_W)) begin
                            // Binary search, MSB first
                            sar_reg[3'(RES_W-1) - bit_cnt_reg[2:0]] <= comparator_in;
                            dac_code_out <= (sar_reg | (comparator_in ?
                                (8'h80 >> bit_cnt_reg[2:0]) : 8'h00))
                                | ((bit_cnt_reg < 4'(RES_W-1)) ?
                                   (8'h40 >> bit_cnt_reg[2:0]) : 8'h00);
                            if (!comparator_in) begin
                                dac_code_out[3'(RES_W-1) - bit_cnt_reg[2:0]] <= 1'b0;
                            end
                        end
                        if (store) begin
                            hold_out <= 1'b0;
                            if (!mode_reg.repeat_select
                                && (mode_reg.scan == SCAN_SINGLE
                                    || (wr_slot == PTR_W'(SLOTS - 1)))) begin
                                state_reg <= ST_IDLE;
                                start_out <= 1'b0;
                                busy_reg  <= 1'b0;
                            end else if (mode_reg.repeat_select && (start_clear_in || !start_out)
                                && (mode_reg.scan == SCAN_SINGLE
                                    || wr_slot == PTR_W'(SLOTS - 1))) begin
                                state_reg <= ST_IDLE;
                                busy_reg  <= 1'b0;
                            end else begin
                                // Next conversion: same channel, or the next of the four scan channels, back to the first after slot 3
                                scan_idx_reg <= scan_idx_reg + 2'h1;
                                if (mode_reg.scan == SCAN_FOUR) begin
                                    chan_reg <= chan_add(mode_reg.channel, scan_idx_reg + 2'h1);
                                end
                                dly_cnt_reg <= sample_delay_in;
                                hold_out    <= 1'b1;
                                state_reg   <= ST_SAMPLE;
                            end
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result buffer, pointer and flags
    // ------------------------------------------------------------
    logic [RES_W-1:0] result_final;
    // All eight decisions are in by the store tick; the DAC already shows the result
    assign result_final = sar_reg;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_reg[i] <= CODE_ZERO;
            end
        end else if (store) begin
            slot_reg[wr_slot] <= result_final;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !converter_enable_bit_in) begin
            full_reg <= '0;
            ptr_reg  <= PTR_RESET;
            ovr_reg  <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE && start_set_in) begin
                ptr_reg  <= PTR_RESET;
                full_reg <= '0;
            end else begin
                for (int i = 0; i < SLOTS; i++) begin
                    if (store && wr_slot == PTR_W'(i)) begin
                        full_reg[i] <= 1'b1;
                    end else if (result_read_in && result_read_slot_in == PTR_W'(i)) begin
                        full_reg[i] <= 1'b0;
                    end
                end
                if (store) begin
                    ptr_reg <= wr_slot;
                end
            end
            // Set wins over clear for both sticky flags
            if (store && full_reg[wr_slot]) begin
                ovr_reg <= 1'b1;
            end else if (overrun_clear_in) begin
                ovr_reg <= 1'b0;
            end
            // Done on single finish, a full slot-3 pass, or a single-channel stop
            if (store && ((mode_reg.scan == SCAN_SINGLE && !mode_reg.repeat_select)
                          || wr_slot == PTR_W'(SLOTS - 1)
                          || (mode_reg.repeat_select && mode_reg.scan == SCAN_SINGLE
                              && (!start_out || start_clear_in)))) begin
                done_reg <= 1'b1;
            end else if (result_read_in) begin
                done_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            mux_select_out   <= '0;
            result_slots_out <= '0;
            irq_out          <= 1'b0;
        end else begin
            mux_select_out <= chan_reg;
            for (int i = 0; i < SLOTS; i++) begin
                result_slots_out[i*RES_W +: RES_W] <= slot_reg[i];
            end
            irq_out <= done_reg & int_enable_in
                       & converter_enable_bit_in;
        end
    end

endmodule : adc_conversion_sequencer

// ===== adc_seq_monitor.sv
`timescale 1ns/1ps
module adc_seq_monitor
    import adc_seq_pkg::*;
(
    // Clock and reset
    input wire logic                            sys_clk_in,
    input wire logic                            sys_rst_in,
    // Controls
    input wire logic                            converter_enable_bit_in,
    input wire logic                            int_enable_in,
    input wire adc_seq_pkg::converter_mode_s    converter_mode_reg_in,
    input wire logic                            start_set_in,
    input wire logic                            start_clear_in,
    input wire logic                            overrun_clear_in,
    input wire logic                            result_read_in,
    // Status
    input wire logic                            start_out,
    input wire adc_seq_pkg::converter_status_s  converter_status_reg_out,
    input wire logic                            irq_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    converter_status_s st;
    logic              en;
    assign st = converter_status_reg_out;
    assign en = converter_enable_bit_in;
    sequence s_take;
        start_set_in && en && !st.busy && !start_out && !converter_mode_reg_in.scan[1] &&
        converter_mode_reg_in.channel < NUM_CH;
    endsequence
    sequence s_single_end;
        $fell(start_out) && en && !$past(start_clear_in) && !converter_mode_reg_in.repeat_select;
    endsequence
    property p_reset_idle;
        $fell(sys_rst_in) |-> st == {PTR_RESET, 3'h0} && !start_out && !irq_out;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("state not idle after reset");
    property p_disable;
        !en |=> !start_out && !st.busy && !st.done && !st.overrun_flag;
    endproperty
    a_disable: assert property (p_disable) else $error("disable left flags set");
    property p_take;
        s_take |=> start_out && st.busy;
    endproperty
    a_take: assert property (p_take) else $error("valid start not taken");
    property p_refuse;
        start_set_in && !start_out && !st.busy && converter_mode_reg_in.channel >= NUM_CH |=> !start_out;
    endproperty
    a_refuse: assert property (p_refuse) else $error("reserved channel started");
    property p_single_end;
        s_single_end |-> !st.busy ##[0:1] st.done;
    endproperty
    a_single_end: assert property (p_single_end) else $error("single end without done");
    property p_irq;
        irq_out == ($past(st.done) && $past(int_enable_in) && $past(en));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt does not follow done");
    property p_read_clear;
        result_read_in && !st.busy |=> !st.done;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read left done set");
    property p_ovr_sticky;
        st.overrun_flag && en && !overrun_clear_in |=> st.overrun_flag;
    endproperty
    a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun dropped");
    property p_ovr_clear;
        overrun_clear_in && !st.busy |=> !st.overrun_flag;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");
    property p_ptr_step;
        $changed(st.last_slot_pointer) && en && $past(en) && !$past(start_set_in)
            |-> st.last_slot_pointer == $past(st.last_slot_pointer) + 2'h1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("pointer skipped a slot");
endmodule : adc_seq_monitor
bind adc_conversion_sequencer adc_seq_monitor i_mon (.sys_clk_in, .sys_rst_in,
    .converter_enable_bit_in, .int_enable_in, .converter_mode_reg_in, .start_set_in,
    .start_clear_in, .overrun_clear_in, .result_read_in, .start_out,
    .converter_status_reg_out, .irq_out);

// ===== analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
    // Converter side
    input  wire logic [adc_seq_pkg::CH_W-1:0]  mux_select_in,
    input  wire logic [adc_seq_pkg::RES_W-1:0] dac_code_in,
    output logic                               comparator_out
);
    import adc_seq_pkg::*;
    // Input 0 at ground, input 11 at reference, to hit both code ends
    function automatic logic [RES_W-1:0] level(input logic [CH_W-1:0] ch);
        if (ch == 4'h0) return CODE_ZERO;
        if (ch == 4'hB) return CODE_FULL;
        return {ch, 4'h5};
    endfunction : level
    assign comparator_out = (level(mux_select_in) >= dac_code_in);
endmodule : analog_front_model

// ===== adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
    import adc_seq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, en = 1'b0, ie = 1'b1, sset = 1'b0, sclr = 1'b0;
    logic oclr = 1'b0, rd = 1'b0, cmp, hold, st, irq;
    logic [1:0]  rslot = 2'h0;
    logic [7:0]  div = 8'h0A, dly = 8'h00, dac;
    logic [3:0]  mux;
    logic [31:0] slots;
    converter_mode_s   mode = '0;
    converter_status_s stat;
    int error_cnt = 0, n_tests = 0, n;
    always #25 clk = ~clk;
    adc_conversion_sequencer #(.DIV_DEFAULT(10)) i_dut (.sys_clk_in(clk), .sys_rst_in(rst),
        .converter_enable_bit_in(en), .int_enable_in(ie), .converter_mode_reg_in(mode),
        .start_set_in(sset), .start_clear_in(sclr), .clk_div_in(div), .sample_delay_in(dly),
        .overrun_clear_in(oclr), .result_read_in(rd), .result_read_slot_in(rslot),
        .comparator_in(cmp), .mux_select_out(mux), .hold_out(hold), .dac_code_out(dac),
        .start_out(st), .converter_status_reg_out(stat), .result_slots_out(slots),
        .irq_out(irq));
    analog_front_model i_afe (.mux_select_in(mux), .dac_code_in(dac), .comparator_out(cmp));
    function automatic logic [7:0] code(input logic [3:0] ch);
        return ch == 4'h0 ? 8'h00 : ch == 4'hB ? 8'hFF : {ch, 4'h5};
    endfunction : code
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic pulse(input int w);
        case (w)
            0: sset = 1'b1;
            1: sclr = 1'b1;
            2: oclr = 1'b1;
            default: rd = 1'b1;
        endcase
        tick(1);
        case (w)
            0: sset = 1'b0;
            1: sclr = 1'b0;
            2: oclr = 1'b0;
            default: rd = 1'b0;
        endcase
    endtask : pulse
    // Disable first, mode changes only while off
    task automatic arm(input logic [1:0] scan, input logic rep, input logic [3:0] ch);
        en = 1'b0;
        tick(2);
        mode = '{scan, rep, ch};
        en = 1'b1;
        tick(EN_SETTLE_CYC);
    endtask : arm
    task automatic wait_bit(input int w);
        n = 0;
        while (n < 3000 && !(w == 0 ? stat.done === 1'b1 :
               w == 1 ? stat.overrun_flag === 1'b1 : stat.busy === 1'b0)) begin
            tick(1);
            n++;
        end
        if (n >= 3000) chk(32'h0, 32'h1);
    endtask : wait_bit
    task automatic t_single;
        arm(SCAN_SINGLE, 1'b0, 4'hB);
        dly = 8'h02;
        pulse(0);
        wait_bit(0);
        chk(n >= 115 && n <= 145, 32'h1);
        tick(2);
        chk(slots[7:0], code(4'hB));
        chk({st, stat.last_slot_pointer, irq}, {1'b0, 2'h0, 1'b1});
        rslot = 2'h0;
        pulse(3);
        tick(2);
        chk({stat.done, irq}, 2'h0);
        dly = 8'h00;
    endtask : t_single
    task automatic t_scan;
        arm(SCAN_FOUR, 1'b0, 4'hA);
        pulse(0);
        wait_bit(0);
        tick(2);
        chk(slots, {code(4'h1), code(4'h0), code(4'hB), code(4'hA)});
        chk({st, stat.last_slot_pointer}, {1'b0, 2'h3});
        arm(SCAN_FOUR, 1'b1, 4'h2);
        pulse(0);
        wait_bit(0);
        tick(2);
        chk(slots, {code(4'h5), code(4'h4), code(4'h3), code(4'h2)});
        chk(st, 1'b1);
        pulse(1);
        wait_bit(2);
        tick(2);
        chk({st, stat}, {1'b0, 2'h3, 1'b1, 1'b0, 1'b1});
    endtask : t_scan
    task automatic t_repeat;
        arm(SCAN_SINGLE, 1'b1, 4'h3);
        pulse(0);
        wait_bit(0);
        tick(2);
        chk(slots, {4{code(4'h3)}});
        chk({st, stat.overrun_flag}, 2'h2);
        wait_bit(1);
        chk({st, stat.last_slot_pointer}, {1'b1, 2'h0});
        pulse(3);
        pulse(1);
        wait_bit(2);
        tick(2);
        chk({st, stat}, {1'b0, 2'h1, 1'b1, 1'b0, 1'b1});
        pulse(2);
        tick(2);
        chk(stat.overrun_flag, 1'b0);
    endtask : t_repeat
    task automatic t_refuse;
        arm(SCAN_SINGLE, 1'b0, 4'hC);
        pulse(0);
        tick(3);
        chk({st, stat.busy}, 2'h0);
        arm(2'h2, 1'b0, 4'h5);
        pulse(0);
        tick(3);
        chk({st, stat.busy}, 2'h0);
        arm(SCAN_SINGLE, 1'b0, 4'h5);
        pulse(0);
        tick(20);
        en = 1'b0;
        tick(2);
        chk({st, stat}, {1'b0, PTR_RESET, 3'h0});
    endtask : t_refuse
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        tick(2);
        rst = 1'b0;
        tick(1);
        chk({st, stat, irq}, {1'b0, PTR_RESET, 3'h0, 1'b0});
        t_single();
        t_scan();
        t_repeat();
        t_refuse();
        print_verdict();
    end
endmodule : adc_conversion_sequencer_tb
